// File: pfs_pkg.sv
// Constants and types for the power-manager fault status bank.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package pfs_pkg;

  // ---------------------------------------------------------------
  // Register selectors
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SEL_INPUT,
    SEL_THERM,
    SEL_CML,
    SEL_VEND,
    SEL_PINS,
    SEL_COMMON,
    SEL_INFO
  } pfs_sel_t;

  // ---------------------------------------------------------------
  // Supported bits and alert qualifiers
  // ---------------------------------------------------------------
  localparam logic [7:0]  SUP_INPUT     = 8'haa;
  localparam logic [7:0]  ALERT_INPUT   = 8'h80;
  localparam logic [7:0]  SUP_THERM     = 8'hd0;
  localparam logic [7:0]  SUP_CML       = 8'hfb;
  localparam logic [7:0]  SUP_VEND_SH   = 8'hfc;
  localparam int          VEND_LOG_BIT  = 3;
  localparam int          VEND_GPIO_BIT = 0;

  // Default alert masks, a one blocks that bit from alert
  localparam logic [7:0]  MASK_INPUT    = 8'h00;
  localparam logic [7:0]  MASK_THERM    = 8'h00;
  localparam logic [7:0]  MASK_CML      = 8'h00;
  localparam logic [7:0]  MASK_VEND     = 8'h11;

  // ---------------------------------------------------------------
  // Read-only word layouts
  // ---------------------------------------------------------------
  localparam logic [15:0] PIN_RSV_MASK  = 16'h3000;
  localparam int          INFO_ECC_BIT  = 5;
  localparam int          CMN_NO_ALERT  = 7;
  localparam int          CMN_NOT_BUSY  = 6;
  localparam int          CMN_NO_CALC   = 5;
  localparam int          CMN_NO_TRANS  = 4;
  localparam int          CMN_NVM_INIT  = 3;
  localparam int          CMN_SHCLK_TO  = 1;
  localparam int          CMN_WP_PIN    = 0;
  localparam int          SUM_MFR_BIT   = 12;
  localparam int          PAGES         = 2;

endpackage
`default_nettype wire

// File: pfs_flag_bank.sv
// Sticky fault flags with per-bit clear; a set beats a clear.
// Assumes set and clear vectors are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module pfs_flag_bank #(
  parameter int         WIDTH   = 8,
  parameter logic [7:0] SUPPORT = 8'hff
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Set and clear strobes
  input  wire logic [WIDTH-1:0] set,
  input  wire logic [WIDTH-1:0] clr,
  // Flag state
  output logic      [WIDTH-1:0] flags_q
);

  logic [WIDTH-1:0] flags_d;

  // Clear first, then set, so a coincident event survives
  always_comb begin
    flags_d = ((flags_q & ~clr) | set) & SUPPORT[WIDTH-1:0];
  end

  // Flag registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

endmodule // pfs_flag_bank
`default_nettype wire

// File: pfs_status_bank.sv
// Fault status bank of a dual-channel power manager: sticky fault
// bytes, read-only pin, common and info words, alert request.
// Assumes a transaction layer above that decodes commands into the
// access strobes below and that inputs are synchronous to clk.
//
// Operation
// - Input byte bits 7,5,3,1; others zero.
// - Only input bit 7 alerts; W1C clears bit 7 only.
// - Thermal byte bits 7,6,4; others zero.
// - Thermal, comm bits alert; write-one clears.
// - Comm byte seven flags, bit 2 reserved.
// - Vendor byte bits 7..2 and 0 defined.
// - Vendor byte shared, bit 0 per page.
// - Any vendor bit sets summary bit.
// - Vendor write-one clears; log bit erase only.
// - Unmasked vendor bits raise the alert.
// - Pin word upper byte layout, 13:12 zero.
// - Pin word lower byte run, GPIO bits.
// - Pin word read-only, one means true.
// - Common byte read-only status flag set.
// - Info word bit 5 ECC status only.
// - ECC bit refreshed on reload, reset, POR.
// - Summary bit sits at word bit 12.
// - Vendor alert mask defaults to 0x11.
`timescale 1ns/1ps
`default_nettype none
module pfs_status_bank (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  // Register access
  input  wire pfs_pkg::pfs_sel_t     acc_sel,
  input  wire logic                  acc_page,
  input  wire logic                  acc_wr,
  input  wire logic [7:0]            acc_wdata,
  input  wire logic                  acc_rd,
  output logic      [15:0]           rd_data_q,
  output logic                       rd_valid_q,
  // Global commands, one-cycle pulses
  input  wire logic                  clear_all,
  input  wire logic                  log_erase,
  input  wire logic                  ecc_refresh,
  // Fault events, one-cycle or level
  input  wire logic [7:0]            input_set,
  input  wire logic [1:0][7:0]       thermal_set,
  input  wire logic [7:0]            cml_set,
  input  wire logic [7:0]            vendor_set,
  input  wire logic [1:0]            gpio_ext_low,
  // Live pin and common conditions
  input  wire logic [15:0]           pin_state_in,
  input  wire logic                  busy,
  input  wire logic                  calc_pending,
  input  wire logic                  in_transition,
  input  wire logic                  nvm_init,
  input  wire logic                  shared_sequencing_clock_timeout,
  input  wire logic                  wp_pin,
  input  wire logic                  ecc_clean,
  // Alert and summary
  output logic                       alert_q,
  output logic      [1:0][15:0]      summary_q
);
  import pfs_pkg::*;

  // ---------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------
  logic [7:0]       wr_mask;
  logic [7:0]       clr_input;
  logic [7:0]       clr_cml;
  logic [7:0]       clr_vend;
  logic [1:0][7:0]  clr_therm;
  logic [1:0]       clr_gpio;

  // Write-one clear per register, clear-all on top
  always_comb begin
    wr_mask   = acc_wr ? acc_wdata : 8'h00;
    clr_input = ((acc_sel == SEL_INPUT) ? (wr_mask & ALERT_INPUT) : 8'h00)
                | (clear_all ? 8'hff : 8'h00);
    clr_cml   = ((acc_sel == SEL_CML) ? wr_mask : 8'h00)
                | (clear_all ? 8'hff : 8'h00);
    clr_vend  = ((acc_sel == SEL_VEND) ? wr_mask : 8'h00)
                | (clear_all ? 8'hff : 8'h00);
    clr_vend[VEND_LOG_BIT] = log_erase;
    for (int p = 0; p < PAGES; p++) begin
      clr_therm[p] = ((acc_sel == SEL_THERM && acc_page == p[0]) ? wr_mask : 8'h00)
                     | (clear_all ? 8'hff : 8'h00);
      clr_gpio[p]  = ((acc_sel == SEL_VEND && acc_page == p[0])
                      & wr_mask[VEND_GPIO_BIT]) | clear_all;
    end
  end

  // ---------------------------------------------------------------
  // Sticky flags
  // ---------------------------------------------------------------
  logic [7:0]       input_q;
  logic [7:0]       cml_q;
  logic [7:0]       vend_q;
  logic [1:0][7:0]  therm_q;
  logic [1:0]       gpio_q;
  logic [1:0][7:0]  vend_page;

  // Input supply byte, unsupported bits forced low
  pfs_flag_bank #(.WIDTH(8), .SUPPORT(SUP_INPUT)) u_input (
    .clk     (clk),
    .rst_b   (rst_b),
    .set     (input_set),
    .clr     (clr_input),
    .flags_q (input_q)
  );

  // Communication, memory and logic byte
  pfs_flag_bank #(.WIDTH(8), .SUPPORT(SUP_CML)) u_cml (
    .clk     (clk),
    .rst_b   (rst_b),
    .set     (cml_set),
    .clr     (clr_cml),
    .flags_q (cml_q)
  );

  // Vendor byte bits shared by both pages
  pfs_flag_bank #(.WIDTH(8), .SUPPORT(SUP_VEND_SH)) u_vend (
    .clk     (clk),
    .rst_b   (rst_b),
    .set     (vendor_set),
    .clr     (clr_vend),
    .flags_q (vend_q)
  );

  // Per-page thermal byte and external GPIO-low flag
  for (genvar g = 0; g < PAGES; g++) begin : g_page
    pfs_flag_bank #(.WIDTH(8), .SUPPORT(SUP_THERM)) u_therm (
      .clk     (clk),
      .rst_b   (rst_b),
      .set     (thermal_set[g]),
      .clr     (clr_therm[g]),
      .flags_q (therm_q[g])
    );
    pfs_flag_bank #(.WIDTH(1), .SUPPORT(8'h01)) u_gpio (
      .clk     (clk),
      .rst_b   (rst_b),
      .set     (gpio_ext_low[g]),
      .clr     (clr_gpio[g]),
      .flags_q (gpio_q[g])
    );
    assign vend_page[g] = {vend_q[7:1], gpio_q[g]};
  end

  // ---------------------------------------------------------------
  // Alert, summary, ECC status
  // ---------------------------------------------------------------
  logic             alert_d;
  logic [1:0][15:0] summary_d;
  logic             ecc_d;
  logic             ecc_q;
  logic             por_done_q;

  // Alert from unmasked flags, input byte bit 7 only; summary per page
  always_comb begin
    alert_d = |(input_q & ALERT_INPUT & ~MASK_INPUT)
              | |(cml_q & ~MASK_CML);
    for (int p = 0; p < PAGES; p++) begin
      alert_d = alert_d | |(therm_q[p] & ~MASK_THERM)
                | |(vend_page[p] & ~MASK_VEND);
      summary_d[p] = 16'h0000;
      summary_d[p][SUM_MFR_BIT] = |vend_page[p];
    end
    ecc_d = (!por_done_q || ecc_refresh) ? ecc_clean : ecc_q;
  end

  // Alert, summary and ECC registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      alert_q    <= 1'b0;
      summary_q  <= '0;
      ecc_q      <= 1'b0;
      por_done_q <= 1'b0;
    end else begin
      alert_q    <= alert_d;
      summary_q  <= summary_d;
      ecc_q      <= ecc_d;
      por_done_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  logic [15:0] rd_data_d;
  logic [15:0] pins_w;
  logic [7:0]  common_w;
  logic [15:0] info_w;

  // Assemble read-only words and select by register
  always_comb begin
    pins_w   = pin_state_in & ~PIN_RSV_MASK;
    common_w = 8'h00;
    common_w[CMN_NO_ALERT] = ~alert_q;
    common_w[CMN_NOT_BUSY] = ~busy;
    common_w[CMN_NO_CALC]  = ~calc_pending;
    common_w[CMN_NO_TRANS] = ~in_transition;
    common_w[CMN_NVM_INIT] = nvm_init;
    common_w[CMN_SHCLK_TO] = shared_sequencing_clock_timeout;
    common_w[CMN_WP_PIN]   = wp_pin;
    info_w = 16'h0000;
    info_w[INFO_ECC_BIT] = ecc_q;
    rd_data_d = rd_data_q;
    if (acc_rd) begin
      case (acc_sel)
        SEL_INPUT:  rd_data_d = {8'h00, input_q};
        SEL_THERM:  rd_data_d = {8'h00, therm_q[acc_page]};
        SEL_CML:    rd_data_d = {8'h00, cml_q};
        SEL_VEND:   rd_data_d = {8'h00, vend_page[acc_page]};
        SEL_PINS:   rd_data_d = pins_w;
        SEL_COMMON: rd_data_d = {8'h00, common_w};
        SEL_INFO:   rd_data_d = info_w;
        default:    rd_data_d = 16'h0000;
      endcase
    end
  end

  // Read data and valid registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_q  <= 16'h0000;
      rd_valid_q <= 1'b0;
    end else begin
      rd_data_q  <= rd_data_d;
      rd_valid_q <= acc_rd;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_input_zero;
    @(posedge clk) disable iff (!rst_b)
      rd_valid_q && $past(acc_sel) == SEL_INPUT |-> (rd_data_q & 16'hff55) == 16'h0000;
  endproperty
  a_input_zero: assert property (p_input_zero) else $error("input byte spare bit set");

  property p_input_alert;
    @(posedge clk) disable iff (!rst_b)
      input_q[7] && !clear_all |=> alert_q;
  endproperty
  a_input_alert: assert property (p_input_alert) else $error("input fault gave no alert");

  // Checked on the returned byte, so the read mux is covered as well
  property p_therm_zero;
    @(posedge clk) disable iff (!rst_b)
      rd_valid_q && $past(acc_sel) == SEL_THERM |-> (rd_data_q & 16'hff2f) == 16'h0000;
  endproperty
  a_therm_zero: assert property (p_therm_zero) else $error("thermal spare bit set");

  property p_therm_w1c;
    @(posedge clk) disable iff (!rst_b)
      acc_wr && acc_sel == SEL_THERM && !acc_page && acc_wdata[7] && !thermal_set[0][7]
      |=> !therm_q[0][7];
  endproperty
  a_therm_w1c: assert property (p_therm_w1c) else $error("thermal bit not cleared");

  property p_cml_rsv;
    @(posedge clk) disable iff (!rst_b)
      rd_valid_q && $past(acc_sel) == SEL_CML |-> (rd_data_q & 16'hff04) == 16'h0000;
  endproperty
  a_cml_rsv: assert property (p_cml_rsv) else $error("reserved comm bit set");

  property p_vend_pages;
    @(posedge clk) disable iff (!rst_b)
      vend_page[0][7:1] == vend_page[1][7:1] && !vend_page[0][1];
  endproperty
  a_vend_pages: assert property (p_vend_pages) else $error("vendor pages disagree");

  property p_summary;
    @(posedge clk) disable iff (!rst_b)
      ##1 summary_q[0][SUM_MFR_BIT] == $past(|vend_page[0]);
  endproperty
  a_summary: assert property (p_summary) else $error("summary bit wrong");

  property p_log_hold;
    @(posedge clk) disable iff (!rst_b)
      vend_q[VEND_LOG_BIT] && !log_erase |=> vend_q[VEND_LOG_BIT];
  endproperty
  a_log_hold: assert property (p_log_hold) else $error("log bit cleared without erase");

  property p_pll_masked;
    @(posedge clk) disable iff (!rst_b)
      vend_q[4] && (vend_q & 8'hec) == 8'h00 && input_q == 8'h00
      && cml_q == 8'h00 && therm_q == '0 |=> !alert_q;
  endproperty
  a_pll_masked: assert property (p_pll_masked) else $error("masked bit raised alert");

  property p_pins_rsv;
    @(posedge clk) disable iff (!rst_b)
      rd_valid_q && $past(acc_sel) == SEL_PINS |-> rd_data_q[13:12] == 2'b00;
  endproperty
  a_pins_rsv: assert property (p_pins_rsv) else $error("pin reserved bits set");

  property p_ecc_refresh;
    @(posedge clk) disable iff (!rst_b)
      ecc_refresh |=> ecc_q == $past(ecc_clean);
  endproperty
  a_ecc_refresh: assert property (p_ecc_refresh) else $error("ecc status not refreshed");

  c_alert_then_clear: cover property (@(posedge clk) disable iff (!rst_b)
    alert_q ##1 clear_all ##2 !alert_q);
  c_log_erase: cover property (@(posedge clk) disable iff (!rst_b)
    vend_q[VEND_LOG_BIT] ##1 log_erase ##1 !vend_q[VEND_LOG_BIT]);
  c_pins_read: cover property (@(posedge clk) disable iff (!rst_b)
    acc_rd && acc_sel == SEL_PINS ##1 rd_valid_q);

endmodule // pfs_status_bank
`default_nettype wire

// File: pfs_host_model.sv
// Host model that reads and clears the fault status bank.
// Assumes the bank samples its strobes on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module pfs_host_model (
  // Clock
  input  wire logic        clk,
  // Access strobes
  output var pfs_pkg::pfs_sel_t acc_sel,
  output var logic         acc_page,
  output var logic         acc_wr,
  output var logic [7:0]   acc_wdata,
  output var logic         acc_rd,
  // Read answer
  input  wire logic [15:0] rd_data_q,
  input  wire logic        rd_valid_q
);
  import pfs_pkg::*;
  // Idle bus at time zero
  initial begin
    acc_sel = SEL_INPUT;
    acc_page = 1'b0;
    acc_wr = 1'b0;
    acc_wdata = 8'h00;
    acc_rd = 1'b0;
  end
  // Write-one-to-clear, idle data inverted after release
  task automatic wr(input pfs_sel_t s, input logic p, input logic [7:0] v);
    @(negedge clk);
    acc_sel = s;
    acc_page = p;
    acc_wdata = v;
    acc_wr = 1'b1;
    @(negedge clk);
    acc_wr = 1'b0;
    acc_wdata = ~v;
    @(negedge clk);
  endtask
  // Read, answer taken one cycle after the strobe
  task automatic rd(input pfs_sel_t s, input logic p, output logic [15:0] v, output logic ok);
    @(negedge clk);
    acc_sel = s;
    acc_page = p;
    acc_rd = 1'b1;
    @(negedge clk);
    acc_rd = 1'b0;
    v = rd_data_q;
    ok = rd_valid_q;
  endtask
endmodule // pfs_host_model
`default_nettype wire

// File: tb.sv
// Self-checking bench for the fault status bank.
// Assumes pfs_host_model drives the register access side.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pfs_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  pfs_sel_t acc_sel;
  logic acc_page, acc_wr, acc_rd, rd_valid_q, alert_q, clear_all, log_erase, ecc_refresh;
  logic busy, calc_pending, in_transition, nvm_init, shared_sequencing_clock_timeout, wp_pin, ecc_clean;
  logic [7:0] acc_wdata, input_set, cml_set, vendor_set, r, w;
  logic [15:0] rd_data_q, pin_state_in, d;
  logic [1:0][7:0] thermal_set;
  logic [1:0][15:0] summary_q;
  logic [1:0] gpio_ext_low;
  integer seed = 32'h01e44e78;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;
  // Clock
  always #5 clk = ~clk;
  // Design and host
  pfs_status_bank i_pfs_status_bank (.clk, .rst_b, .acc_sel, .acc_page, .acc_wr, .acc_wdata,
    .acc_rd, .rd_data_q, .rd_valid_q, .clear_all, .log_erase, .ecc_refresh, .input_set,
    .thermal_set, .cml_set, .vendor_set, .gpio_ext_low, .pin_state_in, .busy, .calc_pending,
    .in_transition, .nvm_init, .shared_sequencing_clock_timeout, .wp_pin, .ecc_clean, .alert_q, .summary_q);
  pfs_host_model i_pfs_host_model (.clk, .acc_sel, .acc_page, .acc_wr, .acc_wdata, .acc_rd,
    .rd_data_q, .rd_valid_q);
  // Expected common byte
  function automatic logic [7:0] exp_cmn(input logic a, b, c, t, n, s, p);
    return {~a, ~b, ~c, ~t, n, 1'b0, s, p};
  endfunction
  // Verdict and end of run
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic achk(input logic e);
    chk({15'h0, alert_q}, {15'h0, e});
  endtask
  task automatic rchk(input pfs_sel_t s, input logic p, input logic [15:0] e);
    logic v;
    i_pfs_host_model.rd(s, p, d, v);
    chk(d, e);
    chk({15'h0, v}, 16'h0001);
  endtask
  // Drop one-cycle events, then let flags and alert settle
  task automatic fire();
    @(negedge clk);
    input_set = 8'h00;
    thermal_set = '0;
    cml_set = 8'h00;
    vendor_set = 8'h00;
    gpio_ext_low = 2'b00;
    clear_all = 1'b0;
    log_erase = 1'b0;
    ecc_refresh = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic pulse_clear();
    @(negedge clk);
    clear_all = 1'b1;
    fire();
  endtask
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      final_report();
    end
  end
  // --------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------
  initial begin
    {busy, calc_pending, in_transition, nvm_init, shared_sequencing_clock_timeout, wp_pin} = 6'h00;
    ecc_clean = 1'b1;
    pin_state_in = 16'h0000;
    fire();
    repeat (18) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      if (i != 4 && i != 5) rchk(pfs_sel_t'(i), 1'b1, (i == 6) ? 16'h0020 : 16'h0000);
    end
    achk(1'b0);
    $display("test reset done");
    @(negedge clk);
    input_set = 8'hff;
    fire();
    rchk(SEL_INPUT, 1'b0, 16'h00aa);
    achk(1'b1);
    i_pfs_host_model.wr(SEL_INPUT, 1'b0, 8'h2a);
    rchk(SEL_INPUT, 1'b0, 16'h00aa);
    i_pfs_host_model.wr(SEL_INPUT, 1'b0, 8'h80);
    rchk(SEL_INPUT, 1'b0, 16'h002a);
    achk(1'b0);
    $display("test input done");
    @(negedge clk);
    thermal_set[0] = 8'hff;
    fire();
    rchk(SEL_THERM, 1'b0, 16'h00d0);
    rchk(SEL_THERM, 1'b1, 16'h0000);
    achk(1'b1);
    i_pfs_host_model.wr(SEL_THERM, 1'b0, 8'h40);
    rchk(SEL_THERM, 1'b0, 16'h0090);
    pulse_clear();
    rchk(SEL_THERM, 1'b0, 16'h0000);
    achk(1'b0);
    $display("test thermal done");
    for (int k = 0; k < 5; k++) begin
      r = (k == 0) ? 8'h04 : 8'($random(seed));
      w = 8'($random(seed));
      @(negedge clk);
      cml_set = r;
      fire();
      rchk(SEL_CML, k[0], {8'h00, r & 8'hfb});
      achk((r & 8'hfb) != 8'h00);
      i_pfs_host_model.wr(SEL_CML, 1'b0, w);
      rchk(SEL_CML, 1'b0, {8'h00, r & 8'hfb & ~w});
      pulse_clear();
    end
    $display("test comm done");
    @(negedge clk);
    vendor_set = 8'hff;
    gpio_ext_low = 2'b01;
    fire();
    rchk(SEL_VEND, 1'b0, 16'h00fd);
    rchk(SEL_VEND, 1'b1, 16'h00fc);
    chk(summary_q[0], 16'h1000);
    chk(summary_q[1], 16'h1000);
    i_pfs_host_model.wr(SEL_VEND, 1'b1, 8'hff);
    rchk(SEL_VEND, 1'b0, 16'h0009);
    pulse_clear();
    rchk(SEL_VEND, 1'b0, 16'h0008);
    achk(1'b1);
    @(negedge clk);
    log_erase = 1'b1;
    fire();
    rchk(SEL_VEND, 1'b0, 16'h0000);
    chk(summary_q[0], 16'h0000);
    achk(1'b0);
    @(negedge clk);
    vendor_set = 8'h10;
    gpio_ext_low = 2'b11;
    fire();
    rchk(SEL_VEND, 1'b1, 16'h0011);
    chk(summary_q[1], 16'h1000);
    achk(1'b0);
    @(negedge clk);
    vendor_set = 8'h20;
    fire();
    achk(1'b1);
    pulse_clear();
    $display("test vendor done");
    i_pfs_host_model.wr(SEL_PINS, 1'b0, 8'hff);
    for (int k = 0; k < 6; k++) begin
      @(negedge clk);
      pin_state_in = (k == 0) ? 16'hffff : 16'($random(seed));
      rchk(SEL_PINS, k[0], pin_state_in & 16'hcfff);
    end
    $display("test pins done");
    @(negedge clk);
    cml_set = 8'h80;
    fire();
    for (int k = 0; k < 8; k++) begin
      if (k == 4) pulse_clear();
      @(negedge clk);
      {busy, calc_pending, in_transition, nvm_init, shared_sequencing_clock_timeout, wp_pin} = 6'($random(seed));
      rchk(SEL_COMMON, 1'b0, {8'h00, exp_cmn(k < 4, busy, calc_pending, in_transition,
        nvm_init, shared_sequencing_clock_timeout, wp_pin)});
    end
    $display("test common done");
    @(negedge clk);
    ecc_clean = 1'b0;
    i_pfs_host_model.wr(SEL_INFO, 1'b0, 8'hff);
    rchk(SEL_INFO, 1'b0, 16'h0020);
    @(negedge clk);
    ecc_refresh = 1'b1;
    fire();
    rchk(SEL_INFO, 1'b0, 16'h0000);
    ecc_clean = 1'b1;
    rchk(SEL_INFO, 1'b0, 16'h0000);
    @(negedge clk);
    rst_b = 1'b0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    rchk(SEL_INFO, 1'b0, 16'h0020);
    $display("test ecc done");
    final_report();
  end
endmodule // tb
`default_nettype wire
